// ---- logic/sdc_pkg.sv ----
//==========================================================
// Notes on behaviour
// - precharge: feedback follows comparator for PRE_MAX cycles
// - measure only after precharge, configured cycles
// - each cycle sample comparator, drive feedback
// - count high cycles; result is that count
// - total 5000 gives result in millivolts
// - each measurement cycle lasts fixed 25 clocks
// - four channels, two comparators, two inputs
// - total cycle count configurable up to 65535
// - comparator bitstream density decimated to binary
// - dual-slope: time second slope to zero
`default_nettype none
package sdc_pkg;
   //==========================================================
   // timing, counter width and reset channel
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned CYC_CLOCKS      = 25;
   localparam int unsigned PRE_CYCLES_DEF  = 64;
   localparam int unsigned TOTAL_DEF       = 5000;
   localparam int unsigned CNT_W           = 16;
   localparam logic [1:0]  CH_RST          = 2'h0;
   //==========================================================
   // states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_PRE   = 3'b001,
      ST_MEAS  = 3'b010,
      ST_SLOPE = 3'b011,
      ST_DONE  = 3'b100
   } sdc_state_t;
   //==========================================================
   // result carrier
   typedef struct packed {
      logic [1:0]       chan;
      logic [CNT_W-1:0] high_cnt;
      logic [CNT_W-1:0] slope_cnt;
   } sdc_result_t;
endpackage
`default_nettype wire

// ---- logic/sdc_tick.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdc_tick
   import sdc_pkg::*;
#(
   parameter int unsigned PERIOD = CYC_CLOCKS
) (
   // clock and reset
   input  wire logic ref_clk_in,
   input  wire logic nrst_in,
   input  wire logic ce_in,
   // control
   input  wire logic run_in,
   output logic      tick_out
);
   localparam int unsigned W = $clog2(PERIOD);
   logic [W-1:0] cnt_r;
   // fixed period independent of data path
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         cnt_r    <= '0;
         tick_out <= 1'b0;
      end else if (ce_in) begin
         if (!run_in || cnt_r == W'(PERIOD - 1)) begin
            cnt_r <= '0;
         end else begin
            cnt_r <= cnt_r + 1'b1;
         end
         tick_out <= run_in && (cnt_r == W'(PERIOD - 2));
      end
   end
endmodule
`default_nettype wire

// ---- logic/sdc_cmp_mux.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdc_cmp_mux
   import sdc_pkg::*;
(
   // selection
   input  wire logic [1:0] chan_in,
   input  wire logic [1:0] cmp_in,
   // outputs
   output logic            in_sel_out,
   output logic            cmp_out
);
   // bit 1 picks comparator, bit 0 picks its input
   always_comb begin
      in_sel_out = chan_in[0];
      cmp_out    = cmp_in[chan_in[1]];
   end
endmodule
`default_nettype wire

// ---- logic/sdc_seq.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdc_seq
   import sdc_pkg::*;
#(
   parameter int unsigned W       = CNT_W,
   parameter int unsigned PRE_MAX = PRE_CYCLES_DEF
) (
   // clock and reset
   input  wire logic            ref_clk_in,
   input  wire logic            nrst_in,
   input  wire logic            ce_in,
   // control
   input  wire logic            start_in,
   input  wire logic            scan_in,
   input  wire logic [1:0]      chan_in,
   input  wire logic [W-1:0]    total_in,
   input  wire logic            dual_in,
   // analog side
   input  wire logic [1:0]      cmp_in,
   output logic                 feedback_output_bit_out,
   output logic [1:0]           cmp_sel_out,
   output logic                 gnd_sel_out,
   // status and result
   output logic                 busy_out,
   output logic                 done_out,
   output sdc_result_t          result_out
);
   //==========================================================
   // declarations
   localparam int unsigned PW = $clog2(PRE_MAX + 1);
   sdc_state_t     state_r;
   logic [W-1:0]   cyc_r;
   logic [W-1:0]   high_r;
   logic [W-1:0]   slope_r;
   logic [PW-1:0]  pre_r;
   logic [1:0]     chan_r;
   logic [W-1:0]   total_r;
   logic           dual_r;
   logic           scan_r;
   logic           tick;
   logic           cmp;
   logic           in_sel;
   logic           run;
   logic           slope_go;
   assign run = (state_r == ST_PRE) || (state_r == ST_MEAS) || (state_r == ST_SLOPE);
   assign slope_go = (state_r == ST_MEAS) && tick && (cyc_r == total_r - 1'b1) && dual_r;
   //==========================================================
   // submodules
   sdc_tick #(.PERIOD(CYC_CLOCKS)) u_tick (
      .ref_clk_in (ref_clk_in),
      .nrst_in    (nrst_in),
      .ce_in      (ce_in),
      .run_in     (run),
      .tick_out   (tick)
   );
   sdc_cmp_mux u_mux (
      .chan_in    (chan_r),
      .cmp_in     (cmp_in),
      .in_sel_out (in_sel),
      .cmp_out    (cmp)
   );
   //==========================================================
   // sequencer
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         state_r <= ST_IDLE;
         chan_r  <= CH_RST;
         total_r <= W'(TOTAL_DEF);
         dual_r  <= 1'b0;
         scan_r  <= 1'b0;
      end else if (ce_in) begin
         case (state_r)
            ST_IDLE, ST_DONE: begin
               if (start_in) begin
                  state_r <= ST_PRE;
                  chan_r  <= chan_in;
                  total_r <= (total_in == '0) ? W'(1) : total_in;
                  dual_r  <= dual_in;
                  scan_r  <= scan_in;
               end else if (state_r == ST_DONE && scan_r && chan_r != 2'h3) begin
                  // scan walks channels in turn
                  state_r <= ST_PRE;
                  chan_r  <= chan_r + 2'h1;
               end
            end
            ST_PRE: begin
               if (tick && pre_r == PW'(PRE_MAX - 1)) begin
                  state_r <= ST_MEAS;
               end
            end
            ST_MEAS: begin
               if (tick && cyc_r == total_r - 1'b1) begin
                  state_r <= dual_r ? ST_SLOPE : ST_DONE;
               end
            end
            ST_SLOPE: begin
               // grounded input: comparator trips once node reaches zero
               if (tick && (cmp || slope_r == '1)) begin
                  state_r <= ST_DONE;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end
   //==========================================================
   // counters
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         cyc_r   <= '0;
         high_r  <= '0;
         slope_r <= '0;
         pre_r   <= '0;
      end else if (ce_in) begin
         if (state_r == ST_IDLE || state_r == ST_DONE) begin
            cyc_r   <= '0;
            high_r  <= '0;
            slope_r <= '0;
            pre_r   <= '0;
         end else if (tick) begin
            if (state_r == ST_PRE) begin
               pre_r <= pre_r + 1'b1;
            end
            if (state_r == ST_MEAS) begin
               cyc_r <= cyc_r + 1'b1;
               // ones density is the decimated result
               high_r <= high_r + W'(cmp);
            end
            if (state_r == ST_SLOPE) begin
               slope_r <= slope_r + 1'b1;
            end
         end
      end
   end
   //==========================================================
   // feedback, selection and busy outputs
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         feedback_output_bit_out <= 1'b0;
         cmp_sel_out             <= 2'h0;
         gnd_sel_out             <= 1'b0;
         busy_out                <= 1'b0;
      end else if (ce_in) begin
         cmp_sel_out <= {chan_r[1], in_sel};
         busy_out    <= run;
         // discharge starts with the ground switch, not a cycle later
         gnd_sel_out <= (state_r == ST_SLOPE) || slope_go;
         if (state_r == ST_SLOPE || slope_go) begin
            feedback_output_bit_out <= 1'b0;
         end else if (tick && (state_r == ST_PRE || state_r == ST_MEAS)) begin
            // comparator decides next charge pulse
            feedback_output_bit_out <= cmp;
         end
      end
   end
   //==========================================================
   // result: raw count, millivolts when total is 5000 at 5 V
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         done_out   <= 1'b0;
         result_out <= '0;
      end else if (ce_in) begin
         done_out <= 1'b0;
         if (run && state_r != ST_PRE) begin
            if ((state_r == ST_MEAS && tick && cyc_r == total_r - 1'b1 && !dual_r) ||
                (state_r == ST_SLOPE && tick && (cmp || slope_r == '1))) begin
               done_out            <= 1'b1;
               result_out.chan     <= chan_r;
               result_out.high_cnt <= (state_r == ST_MEAS) ? high_r + W'(cmp) : high_r;
               result_out.slope_cnt <= slope_r;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- verification/sdc_seq_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdc_seq_checker
   import sdc_pkg::*;
#(
   parameter int unsigned W = CNT_W
) (
   // clock, reset, control
   input wire logic         ref_clk_in,
   input wire logic         nrst_in,
   input wire logic         ce_in,
   input wire logic         start_in,
   input wire logic         scan_in,
   input wire logic [1:0]   chan_in,
   input wire logic [W-1:0] total_in,
   input wire logic         dual_in,
   // analog side and results
   input wire logic [1:0]   cmp_in,
   input wire logic         feedback_output_bit_out,
   input wire logic [1:0]   cmp_sel_out,
   input wire logic         gnd_sel_out,
   input wire logic         busy_out,
   input wire logic         done_out,
   input wire sdc_result_t  result_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!nrst_in);
   //==========================================================
   // sequences
   sequence s_take;
      start_in && ce_in && !busy_out;
   endsequence
   sequence s_fb_step;
      $changed(feedback_output_bit_out);
   endsequence
   //==========================================================
   // assertions
   a_take_busy: assert property (s_take |-> ##[1:3] busy_out)
      else $error("busy did not follow start");
   a_fb_hold: assert property (s_fb_step |=> $stable(feedback_output_bit_out)[*5])
      else $error("feedback changed off the cycle period");
   a_fb_tracks: assert property (busy_out && $past(busy_out) && !gnd_sel_out ##0 s_fb_step
      |-> feedback_output_bit_out == $past(cmp_in[cmp_sel_out[1]]))
      else $error("feedback does not follow comparator");
   a_done_pulse: assert property (done_out |=> !done_out)
      else $error("done longer than one cycle");
   a_result_hold: assert property (!done_out |-> $stable(result_out))
      else $error("result moved without done");
   a_done_busy: assert property ($rose(done_out) |-> $past(busy_out))
      else $error("done without a conversion");
   a_gnd_busy: assert property (gnd_sel_out |-> busy_out)
      else $error("ground select outside conversion");
   a_cnt_bound: assert property (done_out
      |-> result_out.high_cnt <= ((total_in == 0) ? 1 : total_in))
      else $error("high count above total");
endmodule
`default_nettype wire

// ---- verification/sdc_rc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdc_rc_model (
   input  wire logic        ref_clk_in,
   input  wire logic        fb_in,
   input  wire logic [1:0]  sel_in,
   input  wire logic        gnd_in,
   input  wire logic [39:0] vin_in,
   output logic      [1:0]  cmp_out
);
   int cap = 0;
   int v;
   // fixed charge step of 1000 against a drain of the level, so density of highs equals level
   always @(posedge ref_clk_in) begin
      if (gnd_in) begin
         // grounded input: node bleeds toward zero at a fixed rate
         cap <= cap - 200;
      end else begin
         v = int'(vin_in[10*sel_in +: 10]);
         cap <= fb_in ? cap + 1000 - v : cap - v;
      end
   end
   // two comparators share the cap, each with a selectable input
   always_comb begin
      for (int k = 0; k < 2; k++)
         cmp_out[k] = gnd_in ? (cap <= 0) : (int'(vin_in[10*(2*k+sel_in[0]) +: 10]) > cap);
   end
endmodule
`default_nettype wire

// ---- verification/sdc_seq_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdc_seq_tb;
   import sdc_pkg::*;
   localparam int PRE = 8;
   logic        ref_clk_in = 0, nrst_in = 0, start_in = 0, dual_in = 0;
   logic [1:0]  chan_in = 0;
   logic        ce_in = 1, scan_in = 0;
   logic [15:0] total_in = 16'h0014;
   logic [39:0] vin = {10'h0FA, 10'h1F4, 10'h3E8, 10'h000};
   logic        fb, gnd, busy, done;
   logic [1:0]  cmp, sel;
   sdc_result_t res;
   int          n_mismatch = 0, checks = 0, cyc = 0;
   sdc_seq #(.PRE_MAX(PRE)) sdc_seq_i (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
      .ce_in(ce_in), .start_in(start_in), .scan_in(scan_in), .chan_in(chan_in),
      .total_in(total_in), .dual_in(dual_in), .cmp_in(cmp), .feedback_output_bit_out(fb),
      .cmp_sel_out(sel), .gnd_sel_out(gnd), .busy_out(busy), .done_out(done),
      .result_out(res));
   sdc_rc_model sdc_rc_model_i (.ref_clk_in(ref_clk_in), .fb_in(fb), .sel_in(sel),
      .gnd_in(gnd), .vin_in(vin), .cmp_out(cmp));
   initial forever #5 ref_clk_in = ~ref_clk_in;
   always @(posedge ref_clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         conclude();
      end
   end
   task automatic chk(input bit ok);
      checks++;
      if (!ok) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: unexpected value", $time);
      end
   endtask
   // start, poke start once while busy, then judge result and timing
   task automatic conv(input logic [1:0] ch, input logic [15:0] tot, lo, hi,
                       input logic dl);
      int n, e, s;
      bit g;
      sdc_result_t r;
      n = 0;
      g = 0;
      e = (PRE + ((tot == 0) ? 1 : tot)) * 25;
      chan_in <= ch;
      total_in <= tot;
      dual_in <= dl;
      start_in <= 1'b1;
      do begin
         @(posedge ref_clk_in);
         start_in <= (n == 100);
         #1 n++;
         g |= (gnd === 1'b1);
      end while (done !== 1'b1 && n < 5000);
      r = res;
      s = dl ? CYC_CLOCKS * (int'(r.slope_cnt) + 1) : 0;
      chk(n >= e + s - 3 && n <= e + s + 5);
      chk(r.chan === ch);
      chk(r.high_cnt >= lo && r.high_cnt <= hi);
      chk(g == dl && (dl || r.slope_cnt === '0) && r.slope_cnt < 16'h0008);
      @(posedge ref_clk_in);
      #1 chk(done === 1'b0 && res === r);
      @(posedge ref_clk_in);
   endtask
   // scan from channel 2 walks on to 3 and stops there
   task automatic scan_run;
      int n;
      n = 0;
      chan_in  <= 2'h2;
      total_in <= 16'h0014;
      dual_in  <= 1'b0;
      scan_in  <= 1'b1;
      start_in <= 1'b1;
      @(posedge ref_clk_in);
      start_in <= 1'b0;
      scan_in  <= 1'b0;
      do begin
         @(posedge ref_clk_in);
         #1 n++;
      end while (done !== 1'b1 && n < 5000);
      chk(res.chan === 2'h2);
      chk(res.high_cnt >= 16'h0008 && res.high_cnt <= 16'h000C);
      n = 0;
      do begin
         @(posedge ref_clk_in);
         #1 n++;
      end while (done !== 1'b1 && n < 5000);
      chk(n >= (PRE + 20) * 25 - 2 && n <= (PRE + 20) * 25 + 6);
      chk(res.chan === 2'h3);
      chk(res.high_cnt >= 16'h0003 && res.high_cnt <= 16'h0007);
      repeat (30) @(posedge ref_clk_in);
      #1 chk(busy === 1'b0);
      @(posedge ref_clk_in);
   endtask
   // freeze mid-conversion: nothing moves, done slips by the frozen cycles
   task automatic freeze_run;
      int n;
      logic [4:0] o;
      n = 0;
      chan_in  <= 2'h1;
      total_in <= 16'h0014;
      dual_in  <= 1'b0;
      start_in <= 1'b1;
      @(posedge ref_clk_in);
      start_in <= 1'b0;
      repeat (30) @(posedge ref_clk_in);
      ce_in <= 1'b0;
      #1 o = {fb, busy, gnd, sel};
      repeat (40) @(posedge ref_clk_in);
      ce_in <= 1'b1;
      #1 chk(o === {fb, busy, gnd, sel} && busy === 1'b1);
      do begin
         @(posedge ref_clk_in);
         #1 n++;
      end while (done !== 1'b1 && n < 5000);
      chk(n >= (PRE + 20) * 25 - 33 && n <= (PRE + 20) * 25 - 25);
      chk(res.chan === 2'h1 && res.high_cnt === 16'h0014);
      @(posedge ref_clk_in);
   endtask
   // reset in mid-conversion clears it; the next start runs normally
   task automatic reset_run;
      chan_in  <= 2'h2;
      total_in <= 16'h0014;
      dual_in  <= 1'b0;
      start_in <= 1'b1;
      @(posedge ref_clk_in);
      start_in <= 1'b0;
      repeat (100) @(posedge ref_clk_in);
      nrst_in <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
      nrst_in <= 1'b1;
      #1 chk(busy === 1'b0 && done === 1'b0 && fb === 1'b0);
      chk(gnd === 1'b0 && res === '0);
      @(posedge ref_clk_in);
      conv(2'h3, 16'h0014, 16'h0003, 16'h0007, 1'b0);
   endtask
   initial begin
      repeat (20) @(posedge ref_clk_in);
      chk(done === 1'b0 && busy === 1'b0 && fb === 1'b0);
      nrst_in <= 1'b1;
      @(posedge ref_clk_in);
      // duration per run set by precharge plus total, plus slope cycles in dual mode
      conv(2'h0, 16'h0014, 16'h0000, 16'h0000, 1'b0);
      conv(2'h1, 16'h0014, 16'h0014, 16'h0014, 1'b0);
      conv(2'h2, 16'h0014, 16'h0008, 16'h000C, 1'b0);
      conv(2'h3, 16'h0014, 16'h0003, 16'h0007, 1'b0);
      conv(2'h2, 16'h0014, 16'h0008, 16'h000C, 1'b1);
      conv(2'h1, 16'h0000, 16'h0001, 16'h0001, 1'b0);
      scan_run();
      freeze_run();
      reset_run();
      conclude();
   end
   task automatic conclude;
      if (n_mismatch == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
endmodule
bind sdc_seq sdc_seq_checker #(.W(W)) sdc_seq_checker_i (.*);
`default_nettype wire
